/* haptic_pkg.sv */
// Shared constants for the haptic driver two-wire register port
package haptic_pkg;
  localparam logic [6:0] TARGET_ADDR   = 7'h66;
  localparam int         NUM_REGS      = 6;
  localparam logic [7:0] REG_CONFIG    = 8'h00;
  localparam logic [7:0] REG_OSC       = 8'h01;
  localparam logic [7:0] REG_HAPTIC_A  = 8'h02;
  localparam logic [7:0] REG_HAPTIC_B  = 8'h03;
  localparam logic [7:0] REG_LDOH      = 8'h04;
  localparam logic [7:0] REG_LDOV      = 8'h05;
  localparam logic [7:0] RST_CONFIG    = 8'h01;
  localparam logic [7:0] RST_OSC       = 8'h00;
  localparam logic [7:0] RST_HAPTIC_A  = 8'h0A;
  localparam logic [7:0] RST_HAPTIC_B  = 8'h85;
  localparam logic [7:0] RST_LDOH      = 8'h00;
  localparam logic [7:0] RST_LDOV      = 8'h1A;
  localparam int         BIT_CHIP_EN   = 0;
  localparam int         BIT_TRIG      = 1;
  localparam int         BIT_VIB       = 2;
  localparam int         BIT_TEMP      = 3;
  localparam int         BIT_REPEAT    = 4;
  localparam int         CLK_HZ        = 25_000_000;
  localparam int         BUS_BPS       = 400_000;
  // Half bit period for the master, rounded down
  localparam int         HALF_BIT_CYC  = CLK_HZ / (2 * BUS_BPS);
  localparam int         RESP_US       = 40;
  localparam int         RESP_CYC      = RESP_US * (CLK_HZ / 1_000_000);
  localparam int         TICK_MS       = 1;
  localparam int         TICK_CYC      = TICK_MS * (CLK_HZ / 1_000);
endpackage : haptic_pkg

/* haptic_bus_if.sv */
// Two-wire bus between the driver target and the host master
`timescale 1ns/1ns
interface haptic_bus_if;
  logic sclOut;
  logic sclOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;
  logic scl;
  logic sda;
  // Open drain: any enabled low driver wins, pull-up otherwise
  assign scl = !(sclOe && !sclOut);
  assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));
  modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
  modport host (input scl, input sda, output sclOut, output sclOe,
                output sdaHostOut, output sdaHostOe);
endinterface : haptic_bus_if

/* haptic_host.sv */
// Host master issuing single register reads and writes
`timescale 1ns/1ns
module haptic_host
  import haptic_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // Bus
  haptic_bus_if.host      bus,
  // User command
  input  wire logic       reqValid,
  input  wire logic       reqRead,
  input  wire logic [7:0] reqAddr,
  input  wire logic [7:0] reqData,
  output logic            busy,
  output logic            doneValid,
  output logic [7:0]      rdData,
  output logic            ackError
);
  import haptic_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE, H_START, H_BIT, H_ACK, H_RSTART, H_STOP, H_DONE
  } hstate_t;

  typedef struct packed {
    hstate_t     st;
    logic [1:0]  phase;
    logic [15:0] cnt;
    logic [3:0]  bitIdx;
    logic [1:0]  byteNo;
    logic [7:0]  shift;
    logic        isRead;
    logic [7:0]  addr;
    logic [7:0]  data;
    logic        scl;
    logic        sdaLow;
    logic        busy;
    logic        doneValid;
    logic [7:0]  rdData;
    logic        ackError;
  } hs_t;

  hs_t cur;
  hs_t next_s;

  // Byte number: 0 addr+W, 1 reg, 2 data or addr+R, 3 read data
  function automatic logic [7:0] byteFor(input logic [1:0] n,
                                         input hs_t s);
    unique case (n)
      2'd0:    byteFor = {TARGET_ADDR, 1'b0};
      2'd1:    byteFor = s.addr;
      2'd2:    byteFor = s.isRead ? {TARGET_ADDR, 1'b1} : s.data;
      default: byteFor = 8'hFF;
    endcase
  endfunction : byteFor

  always_comb
  begin
    next_s = cur;
    next_s.doneValid = 1'b0;
    if (cur.st != H_IDLE && cur.cnt != 16'h0000)
      next_s.cnt = cur.cnt - 16'h0001;
    else
      unique case (cur.st)
        H_IDLE:
        begin
          next_s.scl = 1'b1;
          next_s.sdaLow = 1'b0;
          if (reqValid)
          begin
            next_s.st = H_START;
            next_s.isRead = reqRead;
            next_s.addr = reqAddr;
            next_s.data = reqData;
            next_s.byteNo = 2'd0;
            next_s.busy = 1'b1;
            next_s.ackError = 1'b0;
            next_s.cnt = 16'(HALF_BIT_CYC);
          end
        end
        H_START, H_RSTART:
        begin
          // Start: sda falls while scl high, then scl falls
          next_s.cnt = 16'(HALF_BIT_CYC);
          if (cur.phase == 2'd0)
          begin
            next_s.scl = 1'b1;
            next_s.sdaLow = 1'b0;
            next_s.phase = 2'd1;
          end
          else if (cur.phase == 2'd1)
          begin
            next_s.sdaLow = 1'b1;
            next_s.phase = 2'd2;
          end
          else
          begin
            next_s.scl = 1'b0;
            next_s.phase = 2'd0;
            next_s.st = H_BIT;
            next_s.bitIdx = 4'd0;
            next_s.shift = byteFor(cur.byteNo, cur);
          end
        end
        H_BIT, H_ACK:
        begin
          next_s.cnt = 16'(HALF_BIT_CYC);
          if (!cur.scl)
          begin
            // Drive data in the same cycle that the clock is released high
            if (cur.st == H_BIT)
              next_s.sdaLow = (cur.byteNo == 2'd3) ? 1'b0 : !cur.shift[7];
            else
              next_s.sdaLow = 1'b0;
            next_s.scl = 1'b1;
          end
          else
          begin
            next_s.scl = 1'b0;
            if (cur.st == H_BIT)
            begin
              next_s.shift = {cur.shift[6:0], bus.sda};
              if (cur.bitIdx == 4'd7)
                next_s.st = H_ACK;
              else
                next_s.bitIdx = cur.bitIdx + 4'd1;
            end
            else
            begin
              if (cur.byteNo == 2'd3)
              begin
                next_s.rdData = cur.shift;
                next_s.st = H_STOP;
              end
              else if (bus.sda)
              begin
                next_s.ackError = 1'b1;
                next_s.st = H_STOP;
              end
              else if (cur.byteNo == 2'd1 && cur.isRead)
              begin
                next_s.byteNo = 2'd2;
                next_s.st = H_RSTART;
              end
              else if (cur.byteNo == 2'd2)
              begin
                if (cur.isRead)
                begin
                  next_s.byteNo = 2'd3;
                  next_s.bitIdx = 4'd0;
                  next_s.shift = 8'hFF;
                  next_s.st = H_BIT;
                end
                else
                  next_s.st = H_STOP;
              end
              else
              begin
                next_s.byteNo = cur.byteNo + 2'd1;
                next_s.bitIdx = 4'd0;
                next_s.shift = byteFor(cur.byteNo + 2'd1, cur);
                next_s.st = H_BIT;
              end
            end
          end
        end
        H_STOP:
        begin
          next_s.cnt = 16'(HALF_BIT_CYC);
          if (cur.phase == 2'd0)
          begin
            next_s.sdaLow = 1'b1;
            next_s.phase = 2'd1;
          end
          else if (cur.phase == 2'd1)
          begin
            next_s.scl = 1'b1;
            next_s.phase = 2'd2;
          end
          else
          begin
            next_s.sdaLow = 1'b0;
            next_s.phase = 2'd0;
            next_s.st = H_DONE;
          end
        end
        H_DONE:
        begin
          next_s.busy = 1'b0;
          next_s.doneValid = 1'b1;
          next_s.st = H_IDLE;
        end
        default:
          next_s.st = H_IDLE;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.st <= H_IDLE;
      cur.scl <= 1'b1;
    end
    else if (ce)
      cur <= next_s;
  end

  assign bus.sclOut = 1'b0;
  assign bus.sclOe = !cur.scl;
  assign bus.sdaHostOut = 1'b0;
  assign bus.sdaHostOe = cur.sdaLow;
  assign busy = cur.busy;
  assign doneValid = cur.doneValid;
  assign rdData = cur.rdData;
  assign ackError = cur.ackError;
endmodule : haptic_host

/* haptic_device.sv */
// Haptic driver target port, register file and bridge sequencer
// Function
// - Six registers readable and writable over bus
// - Both lines rest high when idle
// - Works at bus rates up to 400k
// - Answers only fixed address 1100110
// - Master starts; device acknowledges address, register
// - Write: addr W, reg, data, each acked
// - Read: reg write, repeated start, addr R
// - Acknowledge holds data low ninth clock
// - Master not-acknowledges read data, then stops
// - Vibrate enable held past the delay drives bridge forward only
// - Trigger edge runs forward then reverse
// - Bridge responds about 40 us later
// - Reverse phase brakes motor sharply
// - Registers 00h to 05h, documented defaults
// - Chip enable zero ignores triggers, enables
// - No new pulse before recovery ends
`timescale 1ns/1ns
module haptic_device
  import haptic_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Bus
  haptic_bus_if.device bus,
  // Motor control pins
  input  wire logic haptic_trigger,
  input  wire logic vibrate_enable,
  input  wire logic overTemp,
  // Bridge
  output logic      bridgeOutputPlus,
  output logic      bridge_output_minus,
  output logic      bridgeEnable
);
  import haptic_pkg::*;

  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_REG, T_DATA, T_SEND, T_WAIT}
    tstate_t;
  typedef enum logic [2:0] {M_OFF, M_DELAY, M_FWD, M_COAST, M_REV, M_RECOV}
    mstate_t;

  typedef struct packed {
    logic [1:0]  sclHist;
    logic [1:0]  sdaHist;
    tstate_t     st;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic        ackPhase;
    logic        readMode;
    logic        sdaLow;
    logic [7:0]  ptr;
    logic [0:NUM_REGS-1][7:0] regs;
    logic        trigPrev;
    mstate_t     mst;
    logic [15:0] delayCnt;
    logic [15:0] tickCnt;
    logic [7:0]  phaseTicks;
    logic        plus;
    logic        minus;
    logic        en;
  } ds_t;

  ds_t cur;
  ds_t next_s;

  function automatic logic [7:0] readReg(input ds_t s, input logic [7:0] a);
    readReg = (a < 8'(NUM_REGS)) ? s.regs[a[2:0]] : 8'h00;
  endfunction : readReg

  logic sclRise;
  logic sclFall;
  logic startCond;
  logic stopCond;
  logic chipOn;
  logic trigIn;
  logic vibIn;
  logic tick;

  assign sclRise = cur.sclHist == 2'b01;
  assign sclFall = cur.sclHist == 2'b10;
  // Clock must be high on both samples, so data moving with a rise is no start
  assign startCond = cur.sclHist == 2'b11 && cur.sdaHist == 2'b10;
  assign stopCond = cur.sclHist == 2'b11 && cur.sdaHist == 2'b01;
  assign chipOn = cur.regs[0][BIT_CHIP_EN];
  assign trigIn = chipOn && (haptic_trigger || cur.regs[0][BIT_TRIG]);
  assign vibIn = chipOn && (vibrate_enable || cur.regs[0][BIT_VIB]);
  assign tick = cur.tickCnt == 16'(TICK_CYC - 1);

  always_comb
  begin
    next_s = cur;
    next_s.sclHist = {cur.sclHist[0], bus.scl};
    next_s.sdaHist = {cur.sdaHist[0], bus.sda};
    if (startCond || stopCond)
    begin
      next_s.st = startCond ? T_ADDR : T_IDLE;
      next_s.bitCnt = 4'd0;
      next_s.ackPhase = 1'b0;
      next_s.sdaLow = 1'b0;
    end
    else if (sclRise && !cur.ackPhase && cur.st != T_IDLE
             && cur.st != T_SEND && cur.st != T_WAIT)
    begin
      next_s.shift = {cur.shift[6:0], cur.sdaHist[0]};
      next_s.bitCnt = cur.bitCnt + 4'd1;
    end
    else if (sclFall && cur.st != T_IDLE && cur.st != T_WAIT)
    begin
      if (cur.ackPhase)
      begin
        // Ninth clock over: release and move on
        next_s.ackPhase = 1'b0;
        next_s.sdaLow = 1'b0;
        next_s.bitCnt = 4'd0;
        if (cur.st == T_SEND)
          next_s.st = T_WAIT;
        else if (cur.st == T_ADDR)
          next_s.st = cur.readMode ? T_SEND : T_REG;
        else if (cur.st == T_REG)
          next_s.st = T_DATA;
        else
          next_s.st = T_WAIT;
        if (cur.st == T_ADDR && cur.readMode)
        begin
          next_s.shift = readReg(cur, cur.ptr);
          next_s.sdaLow = !next_s.shift[7];
          next_s.bitCnt = 4'd1;
        end
      end
      else if (cur.st == T_SEND)
      begin
        if (cur.bitCnt == 4'd8)
        begin
          next_s.sdaLow = 1'b0;
          next_s.ackPhase = 1'b1;
        end
        else
        begin
          next_s.sdaLow = !cur.shift[6];
          next_s.shift = {cur.shift[6:0], 1'b0};
          next_s.bitCnt = cur.bitCnt + 4'd1;
        end
      end
      else if (cur.bitCnt == 4'd8)
      begin
        next_s.ackPhase = 1'b1;
        unique case (cur.st)
          T_ADDR:
          begin
            next_s.readMode = cur.shift[0];
            if (cur.shift[7:1] == TARGET_ADDR)
              next_s.sdaLow = 1'b1;
            else
            begin
              next_s.st = T_IDLE;
              next_s.ackPhase = 1'b0;
            end
          end
          T_REG:
          begin
            next_s.ptr = cur.shift;
            next_s.sdaLow = 1'b1;
          end
          default:
          begin
            if (cur.ptr < 8'(NUM_REGS))
              next_s.regs[cur.ptr[2:0]] = cur.shift;
            if (cur.ptr == REG_CONFIG)
              next_s.regs[0][BIT_TEMP] = cur.regs[0][BIT_TEMP] | overTemp;
            next_s.sdaLow = 1'b1;
          end
        endcase
      end
    end
    // Temperature flag latches; a write never clears it
    next_s.regs[0][BIT_TEMP] = next_s.regs[0][BIT_TEMP]
                               | cur.regs[0][BIT_TEMP] | overTemp;

    // Motor sequencer
    next_s.trigPrev = trigIn;
    next_s.tickCnt = tick ? 16'h0000 : cur.tickCnt + 16'h0001;
    unique case (cur.mst)
      M_OFF:
      begin
        next_s.plus = 1'b0;
        next_s.minus = 1'b0;
        next_s.en = 1'b0;
        if ((trigIn && !cur.trigPrev) || vibIn)
        begin
          next_s.mst = M_DELAY;
          next_s.delayCnt = 16'(RESP_CYC - 1);
        end
      end
      M_DELAY:
        if (cur.delayCnt != 16'h0000)
          next_s.delayCnt = cur.delayCnt - 16'h0001;
        else if (vibIn)
        begin
          next_s.mst = M_FWD;
          next_s.phaseTicks = 8'hFF;
        end
        else
        begin
          next_s.mst = M_FWD;
          next_s.tickCnt = 16'h0000;
          next_s.phaseTicks = {3'b000, cur.regs[2][3:0], 1'b0};
        end
      default:
      begin
        next_s.en = cur.mst != M_RECOV && cur.mst != M_COAST;
        next_s.plus = cur.mst == M_FWD;
        next_s.minus = cur.mst == M_REV;
        if (!chipOn)
          next_s.mst = M_OFF;
        else if (cur.mst == M_FWD && vibIn)
          next_s.phaseTicks = 8'hFF;
        else if (cur.mst == M_FWD && cur.phaseTicks == 8'hFF)
          next_s.mst = M_OFF;
        else if (cur.phaseTicks == 8'h00)
          unique case (cur.mst)
            M_FWD:
            begin
              next_s.mst = M_COAST;
              next_s.phaseTicks = {3'b000, cur.regs[2][7:4], 1'b0};
            end
            M_COAST:
            begin
              next_s.mst = M_REV;
              next_s.phaseTicks = {3'b000, cur.regs[3][3:0], 1'b0};
            end
            M_REV:
            begin
              next_s.mst = M_RECOV;
              next_s.phaseTicks = {2'b00, cur.regs[3][7:4], 2'b00};
            end
            default:
              next_s.mst = (cur.regs[0][BIT_REPEAT] && trigIn)
                           ? M_DELAY : M_OFF;
          endcase
        else if (tick)
          next_s.phaseTicks = cur.phaseTicks - 8'h01;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cur <= '0;
      cur.sclHist <= 2'b11;
      cur.sdaHist <= 2'b11;
      cur.st <= T_IDLE;
      cur.mst <= M_OFF;
      cur.regs <= {RST_CONFIG, RST_OSC, RST_HAPTIC_A, RST_HAPTIC_B,
                   RST_LDOH, RST_LDOV};
    end
    else if (ce)
      cur <= next_s;
  end

  assign bus.sdaDevOut = 1'b0;
  assign bus.sdaDevOe = cur.sdaLow;
  assign bridgeOutputPlus = cur.plus;
  assign bridge_output_minus = cur.minus;
  assign bridgeEnable = cur.en;
endmodule : haptic_device

/* haptic_bus_properties.sv */
// Bus protocol checker for the two-wire register port
`timescale 1ns/1ns
module haptic_bus_properties
  import haptic_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus
  input wire logic scl,
  input wire logic sda,
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaHostOut,
  input wire logic sdaHostOe,
  input wire logic sdaDevOut,
  input wire logic sdaDevOe
);
  logic       sdaQ;
  logic       sclQ;
  logic       inFrame;
  logic       dir;
  logic [3:0] bitCnt;
  logic [1:0] byteIdx;
  logic [7:0] shReg;
  logic [7:0] riseGap;
  wire        startEv = sclQ && scl && sdaQ && !sda;
  wire        stopEv  = sclQ && scl && !sdaQ && sda;
  wire        sclRise = !sclQ && scl;

  // Frame tracker; gap saturates so idle time never wraps
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sdaQ    <= 1'h1;
      sclQ    <= 1'h1;
      inFrame <= 1'h0;
      dir     <= 1'h0;
      bitCnt  <= 4'h0;
      byteIdx <= 2'h0;
      shReg   <= 8'h00;
      riseGap <= 8'hFF;
    end
    else
    begin
      sdaQ    <= sda;
      sclQ    <= scl;
      if (sclRise)
        riseGap <= 8'h01;
      else if (riseGap != 8'hFF)
        riseGap <= riseGap + 8'h01;
      if (startEv)
      begin
        inFrame <= 1'h1;
        bitCnt  <= 4'h0;
        byteIdx <= 2'h0;
      end
      else if (stopEv)
        inFrame <= 1'h0;
      else if (sclRise && inFrame)
      begin
        if (bitCnt == 4'h8)
        begin
          bitCnt  <= 4'h0;
          byteIdx <= (byteIdx == 2'h3) ? byteIdx : byteIdx + 2'h1;
          if (byteIdx == 2'h0)
            dir <= shReg[0];
        end
        else
        begin
          bitCnt <= bitCnt + 4'h1;
          shReg  <= {shReg[6:0], sda};
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence ackClock;
    inFrame && sclRise && bitCnt == 4'h8;
  endsequence
  sequence addrByteEnd;
    ackClock ##0 byteIdx == 2'h0;
  endsequence

  idle_lines_high_a: assert property (
    !inFrame && !startEv |-> scl && sda)
    else $error("bus line low while idle");
  open_drain_a: assert property (
    !(sclOe && sclOut) && !(sdaHostOe && sdaHostOut)
    && !(sdaDevOe && sdaDevOut))
    else $error("a driver pushed a line high");
  dev_quiet_idle_a: assert property (
    !inFrame |-> !(sdaDevOe && !sdaDevOut))
    else $error("target pulled data outside a frame");
  addr_fixed_a: assert property (
    addrByteEnd |-> shReg[7:1] == TARGET_ADDR)
    else $error("address byte is not the fixed target address");
  addr_ack_a: assert property (addrByteEnd |-> !sda)
    else $error("address byte not acknowledged");
  reg_ack_a: assert property (
    ackClock ##0 (byteIdx == 2'h1 && !dir) |-> !sda)
    else $error("register byte not acknowledged");
  data_ack_a: assert property (
    ackClock ##0 (byteIdx == 2'h2 && !dir) |-> !sda)
    else $error("write data byte not acknowledged");
  read_nack_a: assert property (
    ackClock ##0 (byteIdx == 2'h1 && dir) |-> sda)
    else $error("read data byte was acknowledged");
  rep_start_a: assert property (
    startEv && inFrame |-> byteIdx == 2'h2 && !dir)
    else $error("repeated start out of place");
  frame_end_a: assert property (
    stopEv && inFrame |-> (dir ? byteIdx == 2'h2 : byteIdx == 2'h3))
    else $error("frame did not carry exactly one data byte");
  sda_hold_a: assert property (
    scl && sclQ |-> $stable(sdaDevOe && !sdaDevOut))
    else $error("target changed data while clock high");
  bus_rate_a: assert property (sclRise |-> riseGap >= 8'h3F)
    else $error("clock faster than 400 kbit/s");
endmodule : haptic_bus_properties

/* haptic_driver_i2c_register_port_tb.sv */
// Self-checking bench: host master and driver target joined by the bus
`timescale 1ns/1ns
module haptic_driver_i2c_register_port_tb;
  import haptic_pkg::*;
  typedef struct packed {logic rd; logic [7:0] addr, data, exp;} row_t;
  localparam int NROWS = 19;
  // Defaults, write/readback of 01h-05h, then unmapped places
  localparam row_t ROWS [NROWS] = '{
    '{1'h1, REG_CONFIG, 8'h00, RST_CONFIG}, '{1'h1, REG_OSC, 8'h00, RST_OSC},
    '{1'h1, REG_HAPTIC_A, 8'h00, RST_HAPTIC_A},
    '{1'h1, REG_HAPTIC_B, 8'h00, RST_HAPTIC_B},
    '{1'h1, REG_LDOH, 8'h00, RST_LDOH}, '{1'h1, REG_LDOV, 8'h00, RST_LDOV},
    '{1'h0, REG_OSC, 8'h0F, 8'h00}, '{1'h0, REG_HAPTIC_A, 8'hA5, 8'h00},
    '{1'h0, REG_HAPTIC_B, 8'h5A, 8'h00}, '{1'h0, REG_LDOH, 8'h1F, 8'h00},
    '{1'h0, REG_LDOV, 8'h13, 8'h00}, '{1'h1, REG_OSC, 8'h00, 8'h0F},
    '{1'h1, REG_HAPTIC_A, 8'h00, 8'hA5}, '{1'h1, REG_HAPTIC_B, 8'h00, 8'h5A},
    '{1'h1, REG_LDOH, 8'h00, 8'h1F}, '{1'h1, REG_LDOV, 8'h00, 8'h13},
    '{1'h0, 8'h06, 8'h77, 8'h00}, '{1'h1, 8'h06, 8'h00, 8'h00},
    '{1'h1, 8'hFF, 8'h00, 8'h00}};

  logic       clk;
  logic       rst;
  logic       reqValid;
  logic       reqRead;
  logic [7:0] reqAddr;
  logic [7:0] reqData;
  logic       busy;
  logic       doneValid;
  logic [7:0] rdData;
  logic       ackError;
  logic       haptic_trigger;
  logic       vibrate_enable;
  logic       overTemp;
  logic       bridgeOutputPlus;
  logic       bridge_output_minus;
  logic       bridgeEnable;
  logic       bad;
  logic       ce;
  logic       prevPlus;
  logic       prevMinus;
  logic [7:0] fwdEdges;
  logic [7:0] revEdges;
  int         num_errors;
  int         compares;
  int         cycles;

  haptic_bus_if busIf();
  haptic_host haptic_host_inst (.clk(clk), .rst(rst), .ce(ce), .bus(busIf),
    .reqValid(reqValid), .reqRead(reqRead), .reqAddr(reqAddr),
    .reqData(reqData), .busy(busy), .doneValid(doneValid), .rdData(rdData),
    .ackError(ackError));
  haptic_device haptic_device_inst (.clk(clk), .rst(rst), .ce(ce),
    .bus(busIf), .haptic_trigger(haptic_trigger),
    .vibrate_enable(vibrate_enable), .overTemp(overTemp),
    .bridgeOutputPlus(bridgeOutputPlus),
    .bridge_output_minus(bridge_output_minus), .bridgeEnable(bridgeEnable));
  haptic_bus_properties haptic_bus_properties_inst (.clk(clk), .rst(rst),
    .scl(busIf.scl), .sda(busIf.sda), .sclOut(busIf.sclOut),
    .sclOe(busIf.sclOe), .sdaHostOut(busIf.sdaHostOut),
    .sdaHostOe(busIf.sdaHostOe), .sdaDevOut(busIf.sdaDevOut),
    .sdaDevOe(busIf.sdaDevOe));

  always #20 clk = ~clk;

  // Freeze both ends one cycle in 97 to exercise the clock enable
  always @(negedge clk)
    ce = cycles % 97 != 50;

  task print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chkBit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chkBit

  // Request held until the host shows busy; ends on the done pulse
  task automatic xfer(input logic rd, input logic [7:0] addr,
                      input logic [7:0] data);
    int n;
    @(negedge clk);
    reqValid = 1'h1;
    reqRead  = rd;
    reqAddr  = addr;
    reqData  = data;
    n = 0;
    do @(negedge clk); while (busy !== 1'h1 && ++n < 10);
    reqValid = 1'h0;
    n = 0;
    do @(negedge clk); while (doneValid !== 1'h1 && ++n < 6000);
    chkBit(doneValid, 1'h1, "transfer completion");
  endtask : xfer

  // Ceiling well above the ~70k cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      num_errors++;
      $display("[FAIL] %0t run did not finish", $time);
      print_verdict;
    end
  end

  initial
  begin
    clk = 1'h0;
    rst = 1'h1;
    {reqValid, reqRead, reqAddr, reqData} = 18'h0;
    {haptic_trigger, vibrate_enable, overTemp} = 3'h0;
    repeat (6) @(negedge clk);
    rst = 1'h0;
    for (int i = 0; i < NROWS; i++)
    begin
      xfer(ROWS[i].rd, ROWS[i].addr, ROWS[i].data);
      if (ROWS[i].rd)
        chk8(rdData, ROWS[i].exp, "register read");
      if (ROWS[i].addr < NUM_REGS)
        chkBit(ackError, 1'h0, "acknowledge");
    end
    // Shutdown must mask the enable pin
    xfer(1'h0, REG_CONFIG, 8'h00);
    vibrate_enable = 1'h1;
    repeat (RESP_CYC + 100) @(negedge clk);
    chkBit(bridgeOutputPlus, 1'h0, "shutdown drive");
    vibrate_enable = 1'h0;
    xfer(1'h0, REG_CONFIG, RST_CONFIG);
    repeat (100) @(negedge clk);
    vibrate_enable = 1'h1;
    repeat (RESP_CYC - 100) @(negedge clk);
    chkBit(bridgeOutputPlus, 1'h0, "early drive");
    repeat (200) @(negedge clk);
    chkBit(bridgeOutputPlus, 1'h1, "forward drive");
    bad = 1'h0;
    repeat (3000)
    begin
      @(negedge clk);
      if (bridge_output_minus !== 1'h0 || bridgeOutputPlus !== 1'h1)
        bad = 1'h1;
    end
    chkBit(bad, 1'h0, "forward only");
    vibrate_enable = 1'h0;
    repeat (4) @(negedge clk);
    chkBit(bridgeOutputPlus, 1'h0, "vibrate released");
    // Over-temperature latch survives until reset
    overTemp = 1'h1;
    repeat (4) @(negedge clk);
    overTemp = 1'h0;
    xfer(1'h1, REG_CONFIG, 8'h00);
    chk8(rdData, RST_CONFIG | 8'h08, "temperature latch");
    rst = 1'h1;
    repeat (6) @(negedge clk);
    chkBit(bridgeOutputPlus | bridge_output_minus, 1'h0, "reset drive");
    rst = 1'h0;
    xfer(1'h1, REG_CONFIG, 8'h00);
    chk8(rdData, RST_CONFIG, "config after reset");
    xfer(1'h1, REG_HAPTIC_A, 8'h00);
    chk8(rdData, RST_HAPTIC_A, "timer after reset");
    // Zero timers: one forward cycle, then one reverse cycle
    xfer(1'h0, REG_HAPTIC_A, 8'h00);
    xfer(1'h0, REG_HAPTIC_B, 8'h00);
    {fwdEdges, revEdges, bad, prevPlus, prevMinus} = 19'h0;
    for (int t = 0; t < 2500; t++)
    begin
      @(negedge clk);
      // Second edge lands inside the delay and must be ignored
      haptic_trigger = t < 200 || t >= 300;
      if (t < 900 && bridgeOutputPlus)
        bad = 1'h1;
      if (bridge_output_minus && fwdEdges == 8'h00)
        bad = 1'h1;
      fwdEdges += 8'(bridgeOutputPlus && !prevPlus);
      revEdges += 8'(bridge_output_minus && !prevMinus);
      prevPlus = bridgeOutputPlus;
      prevMinus = bridge_output_minus;
    end
    chkBit(bad, 1'h0, "haptic order and delay");
    chk8(fwdEdges, 8'h01, "forward pulses");
    chk8(revEdges, 8'h01, "reverse pulses");
    print_verdict;
  end
endmodule : haptic_driver_i2c_register_port_tb
